/* ptpc_defs.vh */
// Purpose: Constants for the periodic timer pulse and capture block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: Offsets are byte addresses; fields are bit positions in the control word
`ifndef PTPC_DEFS_VH
`define PTPC_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define PTPC_OFF_CTRL 5'h00
`define PTPC_OFF_COUNT 5'h04
`define PTPC_OFF_COMPARE_REG_A 5'h08
`define PTPC_OFF_COMPARE_REG_B 5'h0c
`define PTPC_OFF_PERIOD_COMPARE_REG 5'h10
`define PTPC_OFF_STAT 5'h14

////////////////////////////////////////////////////////////////////////////////
// Control word field positions
`define PTPC_CTRL_W 14
`define PTPC_MODE_LSB 0
`define PTPC_OC_LSB 2
`define PTPC_RUN_BIT 4
`define PTPC_CSS_BIT 5
`define PTPC_CLR_LSB 6
`define PTPC_LEF_BIT 8
`define PTPC_CCLR_BIT 9
`define PTPC_OINIT_BIT 10
`define PTPC_OPOL_BIT 11
`define PTPC_ISEL_LSB 12

// Status flag positions
`define PTPC_STAT_A_BIT 0
`define PTPC_STAT_P_BIT 1

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define PTPC_CTRL_RST 14'h0000
`define PTPC_CCR_RST 10'h000
`define PTPC_CNT_W 10

////////////////////////////////////////////////////////////////////////////////
// Encodings
`define PTPC_MODE_CAP 2'b01
`define PTPC_MODE_PULSE 2'b10
`define PTPC_OC_PULSE 2'b11
`define PTPC_OC_RISE 2'b00
`define PTPC_OC_FALL 2'b01
`define PTPC_OC_BOTH 2'b10
`define PTPC_CLR_NONE 2'b00
`define PTPC_ISEL_PIN 2'b00
`define PTPC_RESP_OKAY 2'b00
`define PTPC_RESP_SLVERR 2'b10

`endif

/* ptpc_sync.v */
// Purpose: Two-stage synchroniser with edge detection per input bit
// Assumes: Inputs are asynchronous to mclk
// Notes: Edges are detected between stage two and a third flop only
`timescale 1ns/10ps
module ptpc_sync #(
  parameter N = 3
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Raw pins
  input wire [N-1:0] async_in,
  // Synchronised level and edges
  output wire [N-1:0] sync_lvl,
  output wire [N-1:0] rise,
  output wire [N-1:0] fall
);

  genvar i;

  ////////////////////////////////////////////////////////////////////////////////
  // One chain per input bit
  generate
    for (i = 0; i < N; i = i + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      // Stage one feeds stage two only; pulses under one cycle may vanish
      always @(posedge mclk) begin
        if (reset) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      assign sync_lvl[i] = s2_reg;
      assign rise[i] = s2_reg & ~s3_reg;
      assign fall[i] = ~s2_reg & s3_reg;
    end
  endgenerate

endmodule // ptpc_sync

/* ptpc_top.v */
// Purpose: Periodic timer with single pulse output and capture input modes
// Assumes: AXI4-Lite slave, counter advances every mclk while running
// Notes: HAS_COMPARE_REG_B=1 builds timer 0, HAS_COMPARE_REG_B=0 builds timer 1
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "ptpc_defs.vh"
module ptpc_top #(
  parameter HAS_COMPARE_REG_B = 1
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Trigger and capture sources
  input wire timer_clock_pin,
  input wire capture_input_pin,
  input wire comparator_capture_signal,
  // Timer outputs
  output wire timer_out,
  output wire timer_irq_req
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg awready_reg;
  reg wready_reg;
  reg aw_full_reg;
  reg w_full_reg;
  reg [4:0] waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg arready_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg [`PTPC_CTRL_W-1:0] ctrl_reg, ctrl_next;
  reg [`PTPC_CNT_W-1:0] count_reg, count_next, compare_reg_a_reg, compare_reg_a_next;
  reg [`PTPC_CNT_W-1:0] compare_reg_b_reg, compare_reg_b_next, period_compare_reg_reg, period_compare_reg_next;
  reg [1:0] stat_reg, stat_next;
  reg run_next, out_reg, irq_reg, edge_act, rd_ok;
  reg [31:0] rd_word;
  wire [2:0] pin_rise, pin_fall;
  wire [1:0] op_mode, out_ctrl, capture_clear, input_select_reg, src_idx;
  wire timer_run_bit, capture_source_select, latch_edge_flag, pulse_mode, cap_mode;
  wire cap_rise, cap_fall, a_match, p_match, pulse_a_evt, cap_evt, cap_to_b, cap_clr;
  wire wr_fire, wr_ctrl, wr_compare_reg_a, wr_compare_reg_b, wr_period_compare_reg, wr_stat, wr_ok;
  wire [15:0] ctrl_merge, compare_reg_a_merge, compare_reg_b_merge, period_compare_reg_merge;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of a 16-bit register image
  function [15:0] lane_merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0] strb;
    begin
      lane_merge = {strb[1] ? new_val[15:8] : old_val[15:8], strb[0] ? new_val[7:0] : old_val[7:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: 0 clock pin, 1 capture pin, 2 comparator signal
  ptpc_sync #(
    .N(3)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in({comparator_capture_signal, capture_input_pin, timer_clock_pin}),
    .sync_lvl(),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Control field decode; CCLR, initial state and polarity bits are stored only
  assign op_mode = ctrl_reg[`PTPC_MODE_LSB+1:`PTPC_MODE_LSB];
  assign out_ctrl = ctrl_reg[`PTPC_OC_LSB+1:`PTPC_OC_LSB];
  assign capture_clear = ctrl_reg[`PTPC_CLR_LSB+1:`PTPC_CLR_LSB];
  assign input_select_reg = ctrl_reg[`PTPC_ISEL_LSB+1:`PTPC_ISEL_LSB];
  assign timer_run_bit = ctrl_reg[`PTPC_RUN_BIT];
  assign capture_source_select = ctrl_reg[`PTPC_CSS_BIT];
  assign latch_edge_flag = ctrl_reg[`PTPC_LEF_BIT];
  assign pulse_mode = (op_mode == `PTPC_MODE_PULSE) && (out_ctrl == `PTPC_OC_PULSE);
  assign cap_mode = (op_mode == `PTPC_MODE_CAP);

  ////////////////////////////////////////////////////////////////////////////////
  // Capture source choice; timer 1 has no comparator path
  assign src_idx = capture_source_select ? 2'd0 :
                   ((HAS_COMPARE_REG_B != 0) && (input_select_reg != `PTPC_ISEL_PIN)) ? 2'd2 : 2'd1;
  assign cap_rise = pin_rise[src_idx];
  assign cap_fall = pin_fall[src_idx];

  // Active edge selection from the output field
  always @* begin
    case (out_ctrl)
      `PTPC_OC_RISE: begin
        edge_act = cap_rise;
      end
      `PTPC_OC_FALL: begin
        edge_act = cap_fall;
      end
      `PTPC_OC_BOTH: begin
        edge_act = cap_rise | cap_fall;
      end
      default: begin
        edge_act = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Match and capture events
  assign a_match = timer_run_bit && (count_reg == compare_reg_a_reg);
  assign p_match = timer_run_bit && cap_mode && (period_compare_reg_reg != `PTPC_CCR_RST) && (count_reg == period_compare_reg_reg);
  assign pulse_a_evt = pulse_mode && a_match;
  assign cap_evt = cap_mode && timer_run_bit && edge_act;
  assign cap_to_b = (HAS_COMPARE_REG_B != 0) && (capture_clear != `PTPC_CLR_NONE) &&
                    (latch_edge_flag ? cap_fall : cap_rise);
  assign cap_clr = cap_mode && timer_run_bit && (HAS_COMPARE_REG_B != 0) &&
                   ((capture_clear[0] & cap_rise) | (capture_clear[1] & cap_fall));

  ////////////////////////////////////////////////////////////////////////////////
  // Register write decode
  assign wr_fire = aw_full_reg && w_full_reg;
  assign wr_ctrl = wr_fire && (waddr_reg == `PTPC_OFF_CTRL);
  assign wr_compare_reg_a = wr_fire && (waddr_reg == `PTPC_OFF_COMPARE_REG_A);
  assign wr_compare_reg_b = wr_fire && (waddr_reg == `PTPC_OFF_COMPARE_REG_B) && (HAS_COMPARE_REG_B != 0);
  assign wr_period_compare_reg = wr_fire && (waddr_reg == `PTPC_OFF_PERIOD_COMPARE_REG);
  assign wr_stat = wr_fire && (waddr_reg == `PTPC_OFF_STAT);
  assign wr_ok = wr_ctrl || wr_compare_reg_a || wr_compare_reg_b || wr_period_compare_reg || wr_stat || (waddr_reg == `PTPC_OFF_COUNT);
  assign ctrl_merge = lane_merge({2'b00, ctrl_reg}, wdata_reg[15:0], wstrb_reg[1:0]);
  assign compare_reg_a_merge = lane_merge({6'h00, compare_reg_a_reg}, wdata_reg[15:0], wstrb_reg[1:0]);
  assign compare_reg_b_merge = lane_merge({6'h00, compare_reg_b_reg}, wdata_reg[15:0], wstrb_reg[1:0]);
  assign period_compare_reg_merge = lane_merge({6'h00, period_compare_reg_reg}, wdata_reg[15:0], wstrb_reg[1:0]);

  ////////////////////////////////////////////////////////////////////////////////
  // Control and run bit: hardware set beats hardware clear beats software
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = ctrl_merge[`PTPC_CTRL_W-1:0];
    end
    run_next = ctrl_next[`PTPC_RUN_BIT];
    if (pulse_a_evt) begin
      run_next = 1'b0;
    end
    if (pulse_mode && pin_rise[0]) begin
      run_next = 1'b1;
    end
    ctrl_next[`PTPC_RUN_BIT] = run_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter: zeroed on run rise, holds while stopped
  always @* begin
    count_next = count_reg;
    if (run_next && !timer_run_bit) begin
      count_next = `PTPC_CCR_RST;
    end else if (timer_run_bit) begin
      if (pulse_a_evt) begin
        count_next = count_reg;
      end else if (p_match || cap_clr) begin
        count_next = `PTPC_CCR_RST;
      end else begin
        count_next = count_reg + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare registers: a capture wins over a software write
  always @* begin
    compare_reg_a_next = wr_compare_reg_a ? compare_reg_a_merge[`PTPC_CNT_W-1:0] : compare_reg_a_reg;
    compare_reg_b_next = wr_compare_reg_b ? compare_reg_b_merge[`PTPC_CNT_W-1:0] : compare_reg_b_reg;
    period_compare_reg_next = wr_period_compare_reg ? period_compare_reg_merge[`PTPC_CNT_W-1:0] : period_compare_reg_reg;
    if (cap_evt && !cap_to_b) begin
      compare_reg_a_next = count_reg;
    end
    if (cap_evt && cap_to_b) begin
      compare_reg_b_next = count_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky event flags, write one to clear, set wins
  always @* begin
    stat_next = stat_reg;
    if (wr_stat && wstrb_reg[0]) begin
      stat_next = stat_reg & ~wdata_reg[1:0];
    end
    if (pulse_a_evt || cap_evt) begin
      stat_next[`PTPC_STAT_A_BIT] = 1'b1;
    end
    if (p_match) begin
      stat_next[`PTPC_STAT_P_BIT] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timer state registers
  always @(posedge mclk) begin
    if (reset) begin
      ctrl_reg <= `PTPC_CTRL_RST;
      count_reg <= `PTPC_CCR_RST;
      compare_reg_a_reg <= `PTPC_CCR_RST;
      compare_reg_b_reg <= `PTPC_CCR_RST;
      period_compare_reg_reg <= `PTPC_CCR_RST;
      stat_reg <= 2'b00;
      out_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      count_reg <= count_next;
      compare_reg_a_reg <= compare_reg_a_next;
      compare_reg_b_reg <= compare_reg_b_next;
      period_compare_reg_reg <= period_compare_reg_next;
      stat_reg <= stat_next;
      out_reg <= (ctrl_next[`PTPC_MODE_LSB+1:`PTPC_MODE_LSB] == `PTPC_MODE_PULSE) &&
                 (ctrl_next[`PTPC_OC_LSB+1:`PTPC_OC_LSB] == `PTPC_OC_PULSE) && run_next;
      irq_reg <= pulse_a_evt || cap_evt || p_match;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux
  always @* begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr[4:0])
      `PTPC_OFF_CTRL: begin
        rd_word[`PTPC_CTRL_W-1:0] = ctrl_reg;
      end
      `PTPC_OFF_COUNT: begin
        rd_word[`PTPC_CNT_W-1:0] = count_reg;
      end
      `PTPC_OFF_COMPARE_REG_A: begin
        rd_word[`PTPC_CNT_W-1:0] = compare_reg_a_reg;
      end
      `PTPC_OFF_COMPARE_REG_B: begin
        rd_word[`PTPC_CNT_W-1:0] = (HAS_COMPARE_REG_B != 0) ? compare_reg_b_reg : `PTPC_CCR_RST;
        rd_ok = (HAS_COMPARE_REG_B != 0);
      end
      `PTPC_OFF_PERIOD_COMPARE_REG: begin
        rd_word[`PTPC_CNT_W-1:0] = period_compare_reg_reg;
      end
      `PTPC_OFF_STAT: begin
        rd_word[1:0] = stat_reg;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
    if (s_axi_araddr[7:5] != 3'h0) begin
      rd_ok = 1'b0;
      rd_word = 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels: address and data taken in either order
  always @(posedge mclk) begin
    if (reset) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      waddr_reg <= 5'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `PTPC_RESP_OKAY;
    end else begin
      if (awready_reg && s_axi_awvalid) begin
        awready_reg <= 1'b0;
        aw_full_reg <= 1'b1;
        waddr_reg <= (s_axi_awaddr[7:5] != 3'h0) ? 5'h1f : s_axi_awaddr[4:0];
      end
      if (wready_reg && s_axi_wvalid) begin
        wready_reg <= 1'b0;
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? `PTPC_RESP_OKAY : `PTPC_RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channels: one cycle from address to data
  always @(posedge mclk) begin
    if (reset) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `PTPC_RESP_OKAY;
    end else begin
      if (arready_reg && s_axi_arvalid) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_ok ? `PTPC_RESP_OKAY : `PTPC_RESP_SLVERR;
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output drive
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign timer_out = out_reg;
  assign timer_irq_req = irq_reg;

endmodule // ptpc_top

/* ptpc_top_checker.sv */
// Purpose: Port assertions for ptpc_top
// Assumes: One mclk domain, sync active-high reset
// Notes: Bound to every ptpc_top instance
`timescale 1ns/10ps
module ptpc_top_checker (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Timer outputs
  input wire timer_out,
  input wire timer_irq_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // Handshake steps
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  // Bus channel relations
  a_wr_answer: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write not answered");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_b_release: assert property (b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  a_w_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write ready early");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed");
  // Timer outputs
  a_pulse_irq: assert property (!(timer_out && timer_irq_req)) else $error("irq while pulse high");
  a_reset_idle: assert property (disable iff (1'b0) reset |=> !s_axi_bvalid && !s_axi_rvalid && !timer_out
    && !timer_irq_req) else $error("outputs busy after reset");
endmodule // ptpc_top_checker

bind ptpc_top ptpc_top_checker ptpc_top_checker_inst (.mclk(mclk), .reset(reset),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .timer_out(timer_out), .timer_irq_req(timer_irq_req));

/* ptpc_pins_model.sv */
// Purpose: Far-side model of trigger and capture sources
// Assumes: Levels requested by the bench
// Notes: Pins change just after a rising edge only
`timescale 1ns/10ps
module ptpc_pins_model (
  // Clock
  input wire mclk,
  // Requested levels: clock pin, capture pin, comparator
  input wire [2:0] pin_req,
  // Source pins
  output reg timer_clock_pin,
  output reg capture_input_pin,
  output reg comparator_capture_signal
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle low at start
  initial begin
    timer_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
    comparator_capture_signal = 1'b0;
  end
  // Levels follow the request; bench holds each for 8+ cycles so none is too short
  always @(posedge mclk) begin
    timer_clock_pin <= pin_req[2];
    capture_input_pin <= pin_req[1];
    comparator_capture_signal <= pin_req[0];
  end
endmodule // ptpc_pins_model

/* tb.sv */
// Purpose: Self-checking bench for ptpc_top
// Assumes: Timer 0 build, AXI4-Lite master tasks
// Notes: Pin levels go through ptpc_pins_model
`timescale 1ns/10ps
`include "ptpc_defs.vh"
module tb;
  localparam [7:0] A_CTRL = {3'h0, `PTPC_OFF_CTRL},
    A_CNT = {3'h0, `PTPC_OFF_COUNT},
    A_COMPARE_REG_A = {3'h0, `PTPC_OFF_COMPARE_REG_A},
    A_COMPARE_REG_B = {3'h0, `PTPC_OFF_COMPARE_REG_B},
    A_PERIOD_COMPARE_REG = {3'h0, `PTPC_OFF_PERIOD_COMPARE_REG},
    A_STAT = {3'h0, `PTPC_OFF_STAT};
  reg mclk, reset, awvalid, wvalid, bready, arvalid, rready;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, rd, rd1, keep;
  reg [3:0] wstrb;
  reg [1:0] rs, rs1;
  reg [2:0] pin_req;
  wire awready, wready, bvalid, arready, rvalid, tout, irq, ck_pin, cap_pin, cmp_sig;
  wire [1:0] bresp, rresp, rresp1;
  wire [31:0] rdata, rdata1;
  integer fail_count, checks, cycles;
  ////////////////////////////////////////////////////////////////////////////////
  // Design and far side
  ptpc_top #(.HAS_COMPARE_REG_B(1)) ptpc_top_inst (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_clock_pin(ck_pin), .capture_input_pin(cap_pin), .comparator_capture_signal(cmp_sig),
    .timer_out(tout), .timer_irq_req(irq));
  ptpc_pins_model ptpc_pins_model_inst (.mclk(mclk), .pin_req(pin_req), .timer_clock_pin(ck_pin),
    .capture_input_pin(cap_pin), .comparator_capture_signal(cmp_sig));
  // Timer 1 build shares the bus; its handshakes match timer 0 cycle for cycle
  ptpc_top #(.HAS_COMPARE_REG_B(0)) ptpc_top_t1_inst (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(rdata1),
    .s_axi_rresp(rresp1), .s_axi_rvalid(), .s_axi_rready(rready), .timer_clock_pin(ck_pin),
    .capture_input_pin(cap_pin), .comparator_capture_signal(cmp_sig), .timer_out(), .timer_irq_req());
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock, well under the timer limit
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus and wait tasks
  task check(input string what, input [31:0] exp, input [31:0] seen);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task axi_wr(input [7:0] a, input [31:0] d);
    reg done;
    begin
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge mclk);
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
        if (bvalid === 1'b1) done = 1'b1;
      end
      rs = bresp;
      bready <= 1'b0;
    end
  endtask
  task axi_rd(input [7:0] a);
    reg done;
    begin
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge mclk);
        if (arready === 1'b1) arvalid <= 1'b0;
        if (rvalid === 1'b1) done = 1'b1;
      end
      rd = rdata;
      rs = rresp;
      rd1 = rdata1;
      rs1 = rresp1;
      rready <= 1'b0;
    end
  endtask
  task wait_irq;
    integer i;
    begin
      for (i = 0; i < 40 && irq !== 1'b1; i = i + 1) @(posedge mclk);
      check("irq", 32'h1, {31'h0, irq});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    begin
      axi_rd(A_CTRL);
      check("ctrl reset", 32'h0, rd);
      axi_rd(A_CNT);
      check("count reset", 32'h0, rd);
      axi_rd(A_STAT);
      check("stat reset", 32'h0, rd);
      axi_rd(A_COMPARE_REG_B);
      check("compare_reg_b rresp", 32'h0, {30'h0, rs});
      check("t1 compare_reg_b rresp", {30'h0, `PTPC_RESP_SLVERR}, {30'h0, rs1});
      check("t1 compare_reg_b rdata", 32'h0, rd1);
      axi_rd(8'h40);
      check("unmapped rresp", {30'h0, `PTPC_RESP_SLVERR}, {30'h0, rs});
      check("unmapped rdata", 32'h0, rd);
      axi_wr(8'h40, 32'h1);
      check("unmapped bresp", {30'h0, `PTPC_RESP_SLVERR}, {30'h0, rs});
      $display("test reset done");
    end
  endtask
  task t_pulse;
    begin
      axi_wr(A_COMPARE_REG_A, 32'h3);
      axi_wr(A_CTRL, 32'h1e);
      check("pulse lead", 32'h1, {31'h0, tout});
      wait_irq;
      check("pulse trail", 32'h0, {31'h0, tout});
      axi_rd(A_CNT);
      check("count held", 32'h3, rd);
      axi_rd(A_CTRL);
      check("run cleared", 32'h0e, rd);
      axi_rd(A_STAT);
      check("a event", 32'h1, rd);
      axi_wr(A_STAT, 32'h3);
      pin_req <= 3'b100;
      wait_irq;
      pin_req <= 3'b000;
      axi_rd(A_CNT);
      check("restart count", 32'h3, rd);
      axi_wr(A_STAT, 32'h3);
      $display("test pulse done");
    end
  endtask
  task cap_case(input [31:0] ctl, input [2:0] src, input re, input fe);
    begin
      axi_wr(A_CTRL, ctl);
      axi_wr(A_STAT, 32'h3);
      pin_req <= src;
      repeat (8) @(posedge mclk);
      axi_rd(A_STAT);
      check("rise event", {31'h0, re}, rd);
      axi_wr(A_STAT, 32'h3);
      pin_req <= 3'b000;
      repeat (8) @(posedge mclk);
      axi_rd(A_STAT);
      check("fall event", {31'h0, fe}, rd);
    end
  endtask
  task t_capture;
    begin
      axi_wr(A_PERIOD_COMPARE_REG, 32'h0);
      cap_case(32'h11, 3'b010, 1'b1, 1'b0);
      cap_case(32'h15, 3'b010, 1'b0, 1'b1);
      cap_case(32'h19, 3'b010, 1'b1, 1'b1);
      cap_case(32'h1d, 3'b010, 1'b0, 1'b0);
      cap_case(32'h1011, 3'b001, 1'b1, 1'b0);
      cap_case(32'h31, 3'b100, 1'b1, 1'b0);
      axi_rd(A_COMPARE_REG_B);
      check("compare_reg_b unused", 32'h0, rd);
      axi_wr(A_CTRL, 32'h159);
      pin_req <= 3'b010;
      repeat (30) @(posedge mclk);
      pin_req <= 3'b000;
      repeat (8) @(posedge mclk);
      axi_rd(A_COMPARE_REG_B);
      check("width in compare_reg_b", 32'h1, {31'h0, rd >= 32'd28 && rd <= 32'd31});
      $display("test capture done");
    end
  endtask
  task t_period;
    begin
      axi_wr(A_CTRL, 32'h0d);
      axi_wr(A_PERIOD_COMPARE_REG, 32'h5);
      axi_wr(A_STAT, 32'h3);
      axi_wr(A_CTRL, 32'h1d);
      repeat (12) @(posedge mclk);
      axi_rd(A_STAT);
      check("period event", 32'h2, rd);
      axi_rd(A_CNT);
      check("count bound", 32'h1, {31'h0, rd <= 32'd5});
      axi_wr(A_CTRL, 32'h0d);
      axi_rd(A_CNT);
      keep = rd;
      axi_rd(A_CNT);
      check("count stopped", keep, rd);
      $display("test period done");
    end
  endtask
  task test_done;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    fail_count = 0;
    checks = 0;
    cycles = 0;
    reset = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    pin_req = 3'b000;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_pulse;
    t_capture;
    t_period;
    test_done;
  end
endmodule // tb
